/* tdb_pkg.sv */
package tdb_pkg;

	// ==========================================================
	// Frame and tone constants.
	// ==========================================================
	localparam int TDB_NUM_LAGS = 5;
	localparam int TDB_NUM_RC = 4;
	localparam int TDB_WIN_LEN = 80;
	localparam int TDB_FRAME_LEN = 160;
	localparam logic [7:0] TDB_FRAME_LAST = 8'h9F;
	localparam logic [2:0] TDB_FIRST_STAGE = 3'h1;
	localparam logic [2:0] TDB_LAST_STAGE = 3'h4;
	localparam int TDB_DIRECT_SHIFT = 2;
	localparam int TDB_POLE_SHIFT = 16;
	localparam int TDB_SAMPLE_RATE_HZ = 8000;
	localparam int TDB_POLE_FREQ_HZ = 385;
	// Squared cosine of 2*pi*385/8000 in Q15.
	localparam logic signed [31:0] TDB_POLE_COS2_Q15 = 32'sh000074A6;
	localparam logic signed [15:0] TDB_PREDERR_START = 16'sh7FFF;
	localparam logic signed [15:0] TDB_PREDERR_LIMIT = 16'sh05B8;
	localparam int TDB_FLAG_BIT = 15;

	// ==========================================================
	// Window table.
	// ==========================================================
	localparam logic [15:0] TDB_HANN [TDB_WIN_LEN] = '{
		16'h0000, 16'h000C, 16'h0033, 16'h0072, 16'h00CC, 16'h013E, 16'h01CA, 16'h026E,
		16'h032B, 16'h0401, 16'h04EE, 16'h05F3, 16'h070F, 16'h0842, 16'h098C, 16'h0AEB,
		16'h0C5F, 16'h0DE8, 16'h0F84, 16'h1135, 16'h12F8, 16'h14CD, 16'h16B3, 16'h18AA,
		16'h1AB0, 16'h1CC5, 16'h1EE9, 16'h2119, 16'h2356, 16'h259F, 16'h27F2, 16'h2A4F,
		16'h2CB4, 16'h2F21, 16'h3195, 16'h340E, 16'h368C, 16'h390F, 16'h3B93, 16'h3E1A,
		16'h40A1, 16'h4328, 16'h45AE, 16'h4832, 16'h4AB2, 16'h4D2E, 16'h4FA5, 16'h5216,
		16'h547F, 16'h56E0, 16'h5938, 16'h5B86, 16'h5DC9, 16'h5FFF, 16'h622A, 16'h6446,
		16'h6654, 16'h6853, 16'h6A41, 16'h6C1F, 16'h6DEB, 16'h6FA5, 16'h714B, 16'h72DE,
		16'h745D, 16'h75C7, 16'h771B, 16'h7859, 16'h7981, 16'h7A91, 16'h7B8A, 16'h7C6C,
		16'h7D35, 16'h7DE6, 16'h7E7E, 16'h7EFD, 16'h7F63, 16'h7FB0, 16'h7FE3, 16'h7FFC
	};

	// ==========================================================
	// Saturating fixed-point operators.
	// ==========================================================
	function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
		if (x > 32'sh00007FFF) return 16'sh7FFF;
		if (x < -32'sh00008000) return 16'sh8000;
		return x[15:0];
	endfunction : sat16

	function automatic logic signed [15:0] add16(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] s;
		s = 32'(a) + 32'(b);
		return sat16(s);
	endfunction : add16

	function automatic logic signed [15:0] sub16(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] s;
		s = 32'(a) - 32'(b);
		return sat16(s);
	endfunction : sub16

	function automatic logic signed [15:0] abs16(input logic signed [15:0] a);
		if (a == 16'sh8000) return 16'sh7FFF;
		return (a < 0) ? -a : a;
	endfunction : abs16

	function automatic logic signed [15:0] multTrunc(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (a == 16'sh8000 && b == 16'sh8000) return 16'sh7FFF;
		return 16'(p >>> 15);
	endfunction : multTrunc

	function automatic logic signed [15:0] multRound(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b) + 32'sh00004000;
		return sat16(p >>> 15);
	endfunction : multRound

	function automatic logic signed [31:0] lMult(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (p == 32'sh40000000) return 32'sh7FFFFFFF;
		return p <<< 1;
	endfunction : lMult

	function automatic logic signed [31:0] lSub(input logic signed [31:0] a,
			input logic signed [31:0] b);
		logic signed [32:0] d;
		d = 33'(a) - 33'(b);
		if (d > 33'sh07FFFFFFF) return 32'sh7FFFFFFF;
		if (d < -33'sh080000000) return 32'sh80000000;
		return d[31:0];
	endfunction : lSub

	function automatic logic signed [15:0] div16(input logic signed [15:0] num,
			input logic signed [15:0] den);
		logic [31:0] q;
		q = (32'(unsigned'(num)) << 15) / 32'(unsigned'(den));
		if (num == 16'sh0000) return 16'sh0000;
		if (num >= den) return 16'sh7FFF;
		return 16'(q);
	endfunction : div16

	// Leading-bit count of a positive 32-bit value; never called with zero.
	function automatic logic [4:0] norm32(input logic signed [31:0] x);
		logic [4:0] cnt;
		logic [31:0] v;
		cnt = 5'h00;
		v = x;
		for (int i = 0; i < 31; i++) begin
			if (!v[30]) begin
				v = v << 1;
				cnt = cnt + 5'h01;
			end
		end
		return cnt;
	endfunction : norm32

endpackage : tdb_pkg

/* tdb_rom_if.sv */
`timescale 1ns/1ns
interface tdb_rom_if;
	logic [6:0] addr;
	logic [15:0] data;
	modport requester (output addr, input data);
	modport responder (input addr, output data);
endinterface : tdb_rom_if

/* tdb_window_rom.sv */
`timescale 1ns/1ns
module tdb_window_rom
	import tdb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Table port.
	tdb_rom_if.responder rom
);

	// ==========================================================
	// Registered table read.
	// ==========================================================
	logic [15:0] data_reg;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_reg <= 16'h0000;
		end else begin
			data_reg <= (rom.addr < 7'(TDB_WIN_LEN)) ? TDB_HANN[rom.addr] : 16'h0000;
		end
	end

	assign rom.data = data_reg;

endmodule : tdb_window_rom

/* tdb_backend.sv */
// Summary of operation
// - Four reflection coefficients via 16-bit lattice.
// - Unstable stage zeroes remaining coefficients, stops.
// - Coefficient is quotient, negated for positive element.
// - Update first element, then cross-update pairs.
// - Direct coefficients from shifted reflection values.
// - Pole value: second shifted minus doubled square.
// - Real poles end detection without gain test.
// - Pole below 385 Hz clears tone, ends.
// - Prediction error multiplied by one minus square.
// - Tone set when error below 1464.
// - Constant 80-entry window table.
// - Activity decision in bit 15 of word one.
// - Transmit flag in bit 15 of word two.
// - Zero never reaches the normalisation.
// - Uplink instance keeps tone at zero.
// - Window samples and mirrors with rounding.
`timescale 1ns/1ns
module tdb_backend
	import tdb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Frame request.
	input wire logic frameStart,
	input wire logic [4:0][31:0] acfIn,
	input wire logic downlink,
	// Frame result.
	output logic frameDone,
	output logic toneFlag,
	output logic [3:0][15:0] reflection_coefficients,
	// Window port.
	input wire logic winValid,
	input wire logic [7:0] winIndex,
	input wire logic [15:0] winSample,
	output logic winOutValid,
	output logic [15:0] winOut,
	// Coded parameter words.
	input wire logic vadDecision,
	input wire logic transmit_active_flag,
	input wire logic [14:0] first_coded_parameter,
	input wire logic [14:0] second_coded_parameter,
	output logic [15:0] firstCodedWord,
	output logic [15:0] secondCodedWord
);

	// ==========================================================
	// State.
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_STAGE,
		ST_DIRECT,
		ST_POLE,
		ST_GAIN,
		ST_FINISH
	} tdb_state_e;

	typedef struct packed {
		tdb_state_e st;
		logic [2:0] stage;
		logic [4:0][15:0] p;
		logic [4:0][15:0] k;
		logic [4:0][15:0] rc;
		logic [15:0] a1;
		logic [15:0] a2;
		logic tone;
		logic [3:0][15:0] rcOut;
		logic toneOut;
		logic done;
		logic win1;
		logic [15:0] sample1;
		logic winV;
		logic [15:0] winD;
		logic [15:0] word1;
		logic [15:0] word2;
	} tdb_state_s;

	tdb_state_s s_reg;
	tdb_state_s s_next;

	tdb_rom_if romBus();

	tdb_window_rom romInst (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.rom(romBus.responder)
	);

	// Mirror half of the frame onto the table.
	assign romBus.addr = (winIndex < 8'(TDB_WIN_LEN)) ? winIndex[6:0] :
		7'(TDB_FRAME_LAST - winIndex);

	// ==========================================================
	// Next-state logic.
	// ==========================================================
	always_comb begin
		logic [4:0] sh;
		logic [31:0] scaled;
		logic signed [15:0] p0;
		logic signed [15:0] p1;
		logic signed [15:0] r;
		logic signed [15:0] t;
		logic signed [15:0] err;
		logic signed [31:0] lNum;
		logic signed [31:0] sq;
		logic signed [31:0] lim;
		sh = 5'h00;
		scaled = 32'h00000000;
		p0 = s_reg.p[0];
		p1 = s_reg.p[1];
		r = 16'sh0000;
		t = 16'sh0000;
		err = TDB_PREDERR_START;
		lNum = 32'sh00000000;
		sq = 32'sh00000000;
		lim = 32'sh00000000;
		s_next = s_reg;
		s_next.done = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
				if (frameStart) begin
					s_next.st = ST_LOAD;
				end
			end
			ST_LOAD: begin
				s_next.rc = '0;
				s_next.stage = TDB_FIRST_STAGE;
				if (acfIn[0] == 32'h00000000) begin
					s_next.st = ST_DIRECT;
				end else begin
					sh = norm32(acfIn[0]);
					for (int i = 0; i < TDB_NUM_LAGS; i++) begin
						scaled = acfIn[i] << sh;
						s_next.p[i] = scaled[31:16];
						if (i > 0) begin
							s_next.k[5 - i] = scaled[31:16];
						end
					end
					s_next.st = ST_STAGE;
				end
			end
			ST_STAGE: begin
				if (p0 < abs16(p1)) begin
					for (int i = 1; i <= TDB_NUM_RC; i++) begin
						if (3'(i) >= s_reg.stage) begin
							s_next.rc[i] = 16'h0000;
						end
					end
					s_next.st = ST_DIRECT;
				end else begin
					r = div16(abs16(p1), p0);
					if (p1 > 0) begin
						r = sub16(16'sh0000, r);
					end
					s_next.rc[s_reg.stage] = r;
					if (s_reg.stage == TDB_LAST_STAGE) begin
						s_next.st = ST_DIRECT;
					end else begin
						s_next.p[0] = add16(p0, multRound(p1, r));
						for (int m = 1; m < TDB_NUM_RC; m++) begin
							if (m <= TDB_NUM_RC - int'(s_reg.stage)) begin
								s_next.p[m] = add16(s_reg.p[m + 1],
									multRound(s_reg.k[5 - m], r));
								s_next.k[5 - m] = add16(s_reg.k[5 - m],
									multRound(s_reg.p[m + 1], r));
							end
						end
						s_next.stage = s_reg.stage + 3'h1;
					end
				end
			end
			ST_DIRECT: begin
				t = signed'(s_reg.rc[1]) >>> TDB_DIRECT_SHIFT;
				s_next.a1 = add16(t, multRound(s_reg.rc[2], t));
				s_next.a2 = signed'(s_reg.rc[2]) >>> TDB_DIRECT_SHIFT;
				s_next.st = ST_POLE;
			end
			ST_POLE: begin
				lNum = lSub(32'(signed'(s_reg.a2)) <<< TDB_POLE_SHIFT,
					lMult(s_reg.a1, s_reg.a1));
				sq = 32'(signed'(s_reg.a1)) * 32'(signed'(s_reg.a1));
				lim = TDB_POLE_COS2_Q15 * 32'(signed'(s_reg.a2));
				s_next.tone = 1'b0;
				if (lNum <= 0) begin
					s_next.st = ST_FINISH;
				end else if (signed'(s_reg.a1) < 0 && sq > lim) begin
					s_next.st = ST_FINISH;
				end else begin
					s_next.st = ST_GAIN;
				end
			end
			ST_GAIN: begin
				for (int i = 1; i <= TDB_NUM_RC; i++) begin
					t = multTrunc(s_reg.rc[i], s_reg.rc[i]);
					t = sub16(16'sh7FFF, t);
					err = multTrunc(err, t);
				end
				s_next.tone = (sub16(err, TDB_PREDERR_LIMIT) < 0);
				s_next.st = ST_FINISH;
			end
			ST_FINISH: begin
				s_next.rcOut = s_reg.rc[4:1];
				s_next.toneOut = downlink ? s_reg.tone : 1'b0;
				s_next.done = 1'b1;
				s_next.st = ST_IDLE;
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
		s_next.win1 = winValid;
		s_next.sample1 = winSample;
		s_next.winV = s_reg.win1;
		s_next.winD = multRound(s_reg.sample1, romBus.data);
		s_next.word1 = {vadDecision, first_coded_parameter};
		s_next.word2 = {transmit_active_flag, second_coded_parameter};
	end

	// ==========================================================
	// State register.
	// ==========================================================
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs.
	// ==========================================================
	assign frameDone = s_reg.done;
	assign toneFlag = s_reg.toneOut;
	assign reflection_coefficients = s_reg.rcOut;
	assign winOutValid = s_reg.winV;
	assign winOut = s_reg.winD;
	assign firstCodedWord = s_reg.word1;
	assign secondCodedWord = s_reg.word2;

endmodule : tdb_backend

/* tdb_backend_asserts.sv */
`timescale 1ns/1ns
module tdb_backend_asserts
	import tdb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Watched ports.
	input wire logic frameStart,
	input wire logic downlink,
	input wire logic frameDone,
	input wire logic toneFlag,
	input wire logic [3:0][15:0] reflection_coefficients,
	input wire logic winValid,
	input wire logic winOutValid,
	input wire logic vadDecision,
	input wire logic transmit_active_flag,
	input wire logic [14:0] first_coded_parameter,
	input wire logic [14:0] second_coded_parameter,
	input wire logic [15:0] firstCodedWord,
	input wire logic [15:0] secondCodedWord
);
	// ==========================================================
	// Frame tracking.
	// ==========================================================
	logic busy_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
		end else if (frameDone) begin
			busy_reg <= 1'b0;
		end else if (frameStart) begin
			busy_reg <= 1'b1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_take; frameStart && !busy_reg; endsequence
	sequence s_pulse; frameDone ##1 !frameDone; endsequence
	property p_latency; s_take |-> ##[5:11] s_pulse; endproperty
	a_latency: assert property (p_latency)
		else $error("frame result missing or late");
	property p_no_stray; frameDone |-> busy_reg; endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("frame result without a request");
	property p_hold; !frameDone |-> $stable(reflection_coefficients) && $stable(toneFlag); endproperty
	a_hold: assert property (p_hold)
		else $error("result changed outside a frame end");
	property p_uplink; frameDone && !downlink |-> !toneFlag; endproperty
	a_uplink: assert property (p_uplink)
		else $error("uplink tone set");
	property p_win_on; winValid |-> ##2 winOutValid; endproperty
	a_win_on: assert property (p_win_on)
		else $error("windowed sample missing");
	property p_win_off; !$past(winValid, 2) |-> !winOutValid; endproperty
	a_win_off: assert property (p_win_off)
		else $error("stray windowed sample");
	property p_word1; firstCodedWord == {$past(vadDecision), $past(first_coded_parameter)}; endproperty
	a_word1: assert property (p_word1)
		else $error("first coded word wrong");
	property p_word2; secondCodedWord == $past({transmit_active_flag, second_coded_parameter}); endproperty
	a_word2: assert property (p_word2)
		else $error("second coded word wrong");
endmodule : tdb_backend_asserts

/* tdb_enc_model.sv */
`timescale 1ns/1ns
module tdb_enc_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rstn,
	// Frame handshake.
	output logic frameStart,
	output logic [4:0][31:0] acfIn,
	input wire logic frameDone
);
	initial begin
		frameStart = 1'b0;
		acfIn = '0;
	end
	// Lags stay put from the start pulse until the result edge.
	task automatic send(input logic [4:0][31:0] acf, output logic ok);
		@(posedge clk_sys);
		frameStart <= 1'b1;
		acfIn <= acf;
		@(posedge clk_sys);
		frameStart <= 1'b0;
		for (int n = 0; n < 20; n++) begin
			@(negedge clk_sys);
			if (frameDone === 1'b1) break;
		end
		ok = (frameDone === 1'b1);
		@(posedge clk_sys);
		acfIn <= ~acf;
	endtask : send
endmodule : tdb_enc_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import tdb_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic frameStart, frameDone, toneFlag, winOutValid, ok;
	logic downlink = 1'b1;
	logic winValid = 1'b0;
	logic vadDecision = 1'b0;
	logic transmit_active_flag = 1'b0;
	logic [4:0][31:0] acfIn, a;
	logic [3:0][15:0] reflection_coefficients;
	logic [7:0] winIndex = 8'h00;
	logic [15:0] winSample = 16'h0000;
	logic [15:0] winOut, firstCodedWord, secondCodedWord;
	logic [14:0] first_coded_parameter = 15'h0000;
	logic [14:0] second_coded_parameter = 15'h0000;
	logic run = 1'b0;
	logic [16:0] winPipe [2];
	logic [31:0] wordPipe;
	integer seed = 32'h9834;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;

	always #10 clk_sys = ~clk_sys;

	tdb_enc_model u_enc (.clk_sys(clk_sys), .rstn(rstn), .frameStart(frameStart),
		.acfIn(acfIn), .frameDone(frameDone));
	tdb_backend u_dut (.clk_sys(clk_sys), .rstn(rstn), .frameStart(frameStart),
		.acfIn(acfIn), .downlink(downlink), .frameDone(frameDone), .toneFlag(toneFlag),
		.reflection_coefficients(reflection_coefficients), .winValid(winValid),
		.winIndex(winIndex), .winSample(winSample), .winOutValid(winOutValid),
		.winOut(winOut), .vadDecision(vadDecision),
		.transmit_active_flag(transmit_active_flag),
		.first_coded_parameter(first_coded_parameter),
		.second_coded_parameter(second_coded_parameter),
		.firstCodedWord(firstCodedWord), .secondCodedWord(secondCodedWord));

	// ==========================================================
	// Checking helpers.
	// ==========================================================
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_checks++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	function automatic logic [15:0] win_expect(input logic [7:0] i, input logic [15:0] s);
		int p;
		p = $signed(s) * int'(TDB_HANN[(i < 8'h50) ? i : 8'h9F - i]);
		p = (p + 32'h4000) >>> 15;
		return p[15:0];
	endfunction : win_expect

	task automatic frame(input logic [4:0][31:0] acf, input logic [3:0][15:0] rc,
			input logic tone, input logic full);
		u_enc.send(acf, ok);
		check(ok, 1'b1);
		if (full) check(reflection_coefficients, rc);
		check(toneFlag, tone);
	endtask : frame

	// ==========================================================
	// Random traffic and its checks.
	// ==========================================================
	always @(posedge clk_sys) begin
		cycles++;
		if (run) begin
			winValid <= 1'($random(seed));
			winIndex <= (cycles % 4 == 0) ? 8'h9F : 8'($unsigned($random(seed)) % 160);
			winSample <= (cycles % 6 == 0) ? 16'h8000 : 16'($random(seed));
			vadDecision <= 1'($random(seed));
			transmit_active_flag <= 1'($random(seed));
			first_coded_parameter <= 15'($random(seed));
			second_coded_parameter <= 15'($random(seed));
		end
		winPipe[0] <= {winValid, win_expect(winIndex, winSample)};
		winPipe[1] <= winPipe[0];
		wordPipe <= {vadDecision, first_coded_parameter, transmit_active_flag,
			second_coded_parameter};
		if (cycles == 2000) begin
			failures++;
			report_and_stop();
		end
	end

	always @(negedge clk_sys) begin
		if (run) begin
			check(winOutValid, winPipe[1][16]);
			if (winPipe[1][16]) check(winOut, winPipe[1][15:0]);
			check(firstCodedWord, wordPipe[31:16]);
			check(secondCodedWord, wordPipe[15:0]);
		end
	end

	initial begin
		check(TDB_HANN[0], 16'h0000);
		check(TDB_HANN[40], 16'h40A1);
		check(TDB_HANN[79], 16'h7FFC);
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		run <= 1'b1;
		frame({32'h1234, 32'h5678, 32'h9ABC, 32'h1111, 32'h0}, '0, 1'b0, 1'b1);
		frame({96'h0, 32'h7FFFFFFF, 32'h40000000}, '0, 1'b0, 1'b1);
		frame({128'h0, 32'h40000000}, '0, 1'b0, 1'b1);
		frame({96'h0, 32'hE0000000, 32'h40000000}, 64'h1995_1FFD_2AAA_4000, 1'b0, 1'b1);
		frame({96'h0, 32'hC0000000, 32'h40000000}, 64'h0000_0000_0000_7FFF, 1'b0, 1'b1);
		frame({64'h0, 32'hC0000000, 32'h0, 32'h40000000}, 64'h0000_0000_7FFF_0000, 1'b1, 1'b1);
		frame({64'h0, 32'h02F90000, 32'h10000000, 32'h40000000}, 64'hFFA3_0106_0231_E000, 1'b0,
			1'b1);
		downlink <= 1'b0;
		repeat (4) begin
			a = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
			a[0][31] = 1'b0;
			frame(a, '0, 1'b0, 1'b0);
		end
		repeat (20) @(posedge clk_sys);
		report_and_stop();
	end
endmodule : tb_top

bind tdb_backend tdb_backend_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.frameStart(frameStart), .downlink(downlink), .frameDone(frameDone),
	.toneFlag(toneFlag), .reflection_coefficients(reflection_coefficients),
	.winValid(winValid), .winOutValid(winOutValid), .vadDecision(vadDecision),
	.transmit_active_flag(transmit_active_flag),
	.first_coded_parameter(first_coded_parameter),
	.second_coded_parameter(second_coded_parameter),
	.firstCodedWord(firstCodedWord), .secondCodedWord(secondCodedWord));
